// *** src/fsu_top.sv ***
// security state, backdoor key unlock and reset initialisation sequence
// assumes nonvolatile config values are stable inputs; commands launch with a one-cycle strobe
`timescale 1ns/1ps
// Behaviour
// - new stored security byte applies after reset
// - verify-key only with key access enabled
// - key match forces unsecure state
// - all-zero/all-one keys never unlock
// - failed compare blocks verify until reset
// - unlock changes only working security register
// - reset restores stored security byte
// - verify leaves protection registers untouched
// - unsecured chip may rewrite config field
// - reset loads config, protection, option, security
// - complete flag low during init
// - processor flash access stalled during init
// - complete flag set at init end
// - reset aborts running command immediately
// - no command resumes after reset
// - verify without enable sets access error
// - illegal presented key gives access error
// - complete flag set after verify
// - security register loaded from stored byte
module fsu_top
  import fsu_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              cmdLaunch,
  input  wire logic [7:0]        cmdCode,
  input  wire logic [KEY_W-1:0]  presentedKey,
  input  wire logic [KEY_W-1:0]  storedKey,
  input  wire logic [7:0]        storedSecByte,
  input  wire logic [7:0]        storedProtByte,
  input  wire logic [7:0]        storedOptByte,
  input  wire logic [7:0]        storedBlkCfg,
  input  wire logic              accErrClear,
  output logic [7:0]             securityReg,
  output logic [7:0]             protectionReg,
  output logic [7:0]             optionReg,
  output logic [7:0]             blockCfgReg,
  output logic                   commandCompleteFlag,
  output logic                   accessErrorFlag,
  output logic                   cpuStall,
  output logic                   configRewriteOk,
  output logic                   keyLockedOut
);
  // release synchronised so every flop leaves reset on one edge
  logic rstSync1, rstSyncB;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1 <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSyncB <= rstSync1;
    end
  end

  // field decodes, shared by the sequencer, the outputs and the checks
  function automatic logic keyAccessOn(input logic [7:0] s);
    return s[SEC_KEY_ACCESS_ENABLE_LSB +: 2] == SEC_KEY_ACCESS_ENABLE_ON;
  endfunction : keyAccessOn

  function automatic logic secIsOpen(input logic [7:0] s);
    return s[SEC_STATE_LSB +: 2] == SEC_UNSECURE;
  endfunction : secIsOpen

  typedef struct packed {
    fsu_state_t st;
    logic [2:0] step;
    logic [7:0] sec;
    logic [7:0] prot;
    logic [7:0] opt;
    logic [7:0] blk;
    logic       command_complete_flag;
    logic       access_error_flag;
    logic       lockOut;
  } fsu_regs_t;

  fsu_regs_t q, d;
  logic keysMatch, keyIllegal, isVerify, keyEnOn;

  fsu_key_cmp #(.NBYTES(KEY_BYTES)) uCmp (
    .presentedKey (presentedKey),
    .storedKey    (storedKey),
    .keysMatch    (keysMatch),
    .keyIllegal   (keyIllegal)
  );

  assign isVerify = cmdLaunch && (cmdCode == CMD_VERIFY_KEY);
  assign keyEnOn  = keyAccessOn(q.sec);

  always_comb begin
    d = q;
    if (accErrClear) d.access_error_flag = 1'b0;
    case (q.st)
      FSU_INIT: begin
        d.command_complete_flag = 1'b0;
        case (q.step)
          3'h0: d.blk = storedBlkCfg;
          3'h1: d.prot = storedProtByte;
          3'h2: d.opt = storedOptByte;
          default: d.sec = storedSecByte;
        endcase
        d.step = q.step + 3'h1;
        if (q.step == INIT_LAST_STEP) begin
          d.st   = FSU_IDLE;
          d.command_complete_flag = 1'b1;
        end
      end
      // launches while busy are dropped, not queued
      FSU_IDLE: begin
        if (isVerify && q.command_complete_flag) begin
          d.command_complete_flag = 1'b0;
          d.st   = FSU_CMP;
        end
      end
      FSU_CMP: begin
        // gate and lock-out first, so a blocked part never compares
        // disabled: error, no compare
        if (!keyEnOn || q.lockOut || keyIllegal) begin
          d.access_error_flag = 1'b1;
        end else if (keysMatch) begin
          d.sec[SEC_STATE_LSB +: 2] = SEC_UNSECURE;
        end else begin
          d.lockOut = 1'b1;
          d.access_error_flag  = 1'b1;
        end
        d.st = FSU_DONE;
      end
      FSU_DONE: begin
        d.command_complete_flag = 1'b1;
        d.st   = FSU_IDLE;
      end
      default: d.st = FSU_INIT;
    endcase
  end

  // reset aborts and reloads; nothing resumes
  always_ff @(posedge ref_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      q <= '{st: FSU_INIT, step: 3'h0, sec: SEC_RST_VAL, prot: PROT_RST_VAL,
             opt: OPT_RST_VAL, blk: BLK_RST_VAL, command_complete_flag: 1'b0, access_error_flag: 1'b0, lockOut: 1'b0};
    end else begin
      q <= d;
    end
  end

  // stored byte read only at init; protection never written by verify
  assign securityReg         = q.sec;
  assign protectionReg       = q.prot;
  assign optionReg           = q.opt;
  assign blockCfgReg         = q.blk;
  assign commandCompleteFlag = q.command_complete_flag;
  assign accessErrorFlag     = q.access_error_flag;
  assign cpuStall            = q.st == FSU_INIT;
  assign configRewriteOk     = secIsOpen(q.sec);
  assign keyLockedOut        = q.lockOut;

  // reset-load path and verify-result checks
  a_init_no_command_complete_flag: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    cpuStall |-> !commandCompleteFlag) else $error("complete flag set during init");
  a_init_ends: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    $fell(cpuStall) |-> commandCompleteFlag) else $error("init end without complete");
  a_sec_load: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    $fell(cpuStall) |-> securityReg == $past(storedSecByte)) else $error("security not loaded");
  a_verify_done: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (isVerify && q.st == FSU_IDLE && q.command_complete_flag) |-> ##3 commandCompleteFlag) else $error("verify not completed");
  a_no_key_access_enable_err: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (q.st == FSU_CMP && !keyEnOn) |=> accessErrorFlag && $stable(securityReg)) else $error("disabled verify ok");
  a_illegal_err: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (q.st == FSU_CMP && keyIllegal) |=> accessErrorFlag) else $error("illegal key accepted");
  a_match_unsec: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (q.st == FSU_CMP && keyEnOn && !q.lockOut && keysMatch) |=> configRewriteOk) else $error("match not unsecured");
  a_lock_sticky: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    keyLockedOut |=> keyLockedOut) else $error("lockout cleared");
  a_prot_stable: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    !cpuStall |=> $stable(protectionReg) && $stable(optionReg)) else $error("protection changed");
  a_stall_len: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    $rose(rstSyncB) |-> cpuStall[*4] ##1 !cpuStall) else $error("stall length wrong");

  // command-path checks: gate, lock-out and what reset leaves behind
  a_launch_ack: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (isVerify && q.st == FSU_IDLE && q.command_complete_flag) |=> !commandCompleteFlag) else $error("launch not taken");
  a_cmp_from_idle: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (q.st == FSU_CMP) |-> $past(commandCompleteFlag)) else $error("compare without ready");
  a_lock_blocks: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (q.st == FSU_CMP && q.lockOut) |=> accessErrorFlag && $stable(securityReg)) else $error("locked verify ran");
  a_mismatch_lock: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (q.st == FSU_CMP && keyEnOn && !q.lockOut && !keyIllegal && !keysMatch)
    |=> keyLockedOut && accessErrorFlag) else $error("mismatch not locked");
  a_lock_only_fail: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    $rose(keyLockedOut) |-> $past(q.st == FSU_CMP)) else $error("lockout without compare");
  a_sec_only: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (q.st == FSU_CMP) |=> $stable(securityReg[SEC_KEY_ACCESS_ENABLE_LSB +: 2]) && $stable(blockCfgReg))
    else $error("verify touched config");
  a_disabled_keeps: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (q.st == FSU_CMP && !keyEnOn) |=> $stable(keyLockedOut) && $stable(configRewriteOk)) else $error("gate ignored");
  a_unlock_only_match: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    $rose(configRewriteOk) |-> $past(q.st == FSU_CMP) || $past(cpuStall)) else $error("unlock without match");
  a_reset_clean: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    $rose(rstSyncB) |-> !keyLockedOut && !accessErrorFlag && !commandCompleteFlag)
    else $error("state survived reset");
  a_step_bound: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    cpuStall |-> q.step <= INIT_LAST_STEP) else $error("init ran long");
  a_err_sticky: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    (accessErrorFlag && !accErrClear) |=> accessErrorFlag) else $error("error flag dropped");

  c_unlock: cover property (@(posedge ref_clk) disable iff (!rstSyncB) $rose(configRewriteOk));
  c_lockout: cover property (@(posedge ref_clk) disable iff (!rstSyncB) $rose(keyLockedOut));
  c_init_done: cover property (@(posedge ref_clk) disable iff (!rstSyncB) $fell(cpuStall));
  c_illegal_key: cover property (@(posedge ref_clk) disable iff (!rstSyncB) q.st == FSU_CMP && keyIllegal);
  c_disabled_verify: cover property (@(posedge ref_clk) disable iff (!rstSyncB) q.st == FSU_CMP && !keyEnOn);
endmodule : fsu_top

// *** src/fsu_pkg.sv ***
// package for the flash security, backdoor unlock and reset-sequence block
// assumes one 250 MHz clock domain; shared by the top and the key comparator
package fsu_pkg;
  localparam int          KEY_BYTES        = 8;
  localparam int          KEY_W            = 64;
  // security register layout: key enable [7:6], mass erase [5:4], factory [3:2], state [1:0]
  localparam int          SEC_STATE_LSB    = 0;
  localparam int          SEC_KEY_ACCESS_ENABLE_LSB    = 6;
  localparam logic [1:0]  SEC_UNSECURE     = 2'h2;
  localparam logic [1:0]  SEC_KEY_ACCESS_ENABLE_ON     = 2'h2;
  localparam logic [7:0]  SEC_RST_VAL      = 8'hff;
  localparam logic [7:0]  PROT_RST_VAL     = 8'h00;
  localparam logic [7:0]  OPT_RST_VAL      = 8'h00;
  localparam logic [7:0]  BLK_RST_VAL      = 8'h00;
  localparam logic [7:0]  CMD_VERIFY_KEY   = 8'h45;
  // init load: one read cycle per loaded item, four items
  localparam int          INIT_LOAD_STEPS  = 4;
  localparam logic [2:0]  INIT_LAST_STEP   = 3'h3;

  typedef enum logic [1:0] {
    FSU_INIT = 2'b00,
    FSU_IDLE = 2'b01,
    FSU_CMP  = 2'b10,
    FSU_DONE = 2'b11
  } fsu_state_t;
endpackage : fsu_pkg

// *** src/fsu_key_cmp.sv ***
// bytewise backdoor key comparator, combinational
// assumes both keys are stable while the sequencer samples the result
`timescale 1ns/1ps
module fsu_key_cmp
  import fsu_pkg::*;
#(
  parameter int NBYTES = KEY_BYTES
) (
  input  wire logic [8*NBYTES-1:0] presentedKey,
  input  wire logic [8*NBYTES-1:0] storedKey,
  output logic                     keysMatch,
  output logic                     keyIllegal
);
  logic [NBYTES-1:0] byteEq;

  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : gByte
      assign byteEq[gi] = presentedKey[8*gi +: 8] == storedKey[8*gi +: 8];
    end
  endgenerate

  assign keyIllegal = (presentedKey == '0) || (&presentedKey) || (storedKey == '0) || (&storedKey);
  assign keysMatch  = (&byteEq) && !keyIllegal;
endmodule : fsu_key_cmp

// *** dv/fsu_cpu_model.sv ***
// processor-side model that launches verify-key commands
// assumes the caller waits for the complete flag before each call
`timescale 1ns/1ps
module fsu_cpu_model
  import fsu_pkg::*;
(
  input  wire logic             ref_clk,
  output logic                  cmdLaunch,
  output logic [7:0]            cmdCode,
  output logic [KEY_W-1:0]      presentedKey,
  output logic                  accErrClear
);
  initial begin
    cmdLaunch = 1'b0;
    cmdCode = 8'h00;
    presentedKey = '0;
    accErrClear = 1'b0;
  end
  // cut leaves the command running so a reset can hit it
  task automatic issue(input logic [KEY_W-1:0] k, input bit cut);
    @(posedge ref_clk);
    accErrClear <= 1'b1;
    presentedKey <= k;
    cmdCode <= CMD_VERIFY_KEY;
    @(posedge ref_clk);
    accErrClear <= 1'b0;
    cmdLaunch <= 1'b1;
    @(posedge ref_clk);
    cmdLaunch <= 1'b0;
    if (!cut) repeat (4) @(posedge ref_clk);
    #1;
  endtask : issue
endmodule : fsu_cpu_model

// *** dv/testbench.sv ***
// self-checking bench for security unlock and reset sequence
// assumes the cpu model drives commands; stored values are bench levels
`timescale 1ns/1ps
module testbench;
  import fsu_pkg::*;
  localparam logic [KEY_W-1:0] SK = 64'h0123456789abcdef;
  logic             ref_clk, rst_b, cmdLaunch, accErrClear;
  logic             command_complete_flag, access_error_flag, cpuStall, rwOk, lockOut;
  logic [7:0]       cmdCode, sSec, sProt, sOpt, sBlk;
  logic [7:0]       secR, protR, optR, blkR;
  logic [KEY_W-1:0] storedKey, presentedKey;
  int               errors, total_checks;
  fsu_cpu_model u_cpu (.ref_clk(ref_clk), .cmdLaunch(cmdLaunch), .cmdCode(cmdCode),
    .presentedKey(presentedKey), .accErrClear(accErrClear));
  fsu_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmdLaunch(cmdLaunch), .cmdCode(cmdCode),
    .presentedKey(presentedKey), .storedKey(storedKey), .storedSecByte(sSec),
    .storedProtByte(sProt), .storedOptByte(sOpt), .storedBlkCfg(sBlk),
    .accErrClear(accErrClear), .securityReg(secR), .protectionReg(protR),
    .optionReg(optR), .blockCfgReg(blkR), .commandCompleteFlag(command_complete_flag),
    .accessErrorFlag(access_error_flag), .cpuStall(cpuStall), .configRewriteOk(rwOk),
    .keyLockedOut(lockOut));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim;
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic do_reset(input int n);
    int i;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
    chk("ccifRst", 8'h0, {7'h0, command_complete_flag});
    @(posedge ref_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      #1;
      if (command_complete_flag === 1'b1) break;
      chk("stall", 8'h1, {7'h0, cpuStall});
    end
    chk("command_complete_flag", 8'h1, {7'h0, command_complete_flag});
    chk("stallEnd", 8'h0, {7'h0, cpuStall});
    chk("sec", sSec, secR);
    chk("prot", sProt, protR);
    chk("opt", sOpt, optR);
    chk("blk", sBlk, blkR);
    chk("lock", 8'h0, {7'h0, lockOut});
  endtask : do_reset
  initial begin
    #20000;
    errors++;
    end_sim();
  end
  initial begin
    errors = 0;
    total_checks = 0;
    rst_b = 1'b0;
    storedKey = SK;
    sSec = 8'hff;
    sProt = 8'h5a;
    sOpt = 8'ha5;
    sBlk = 8'h3c;
    do_reset(12);
    u_cpu.issue(SK, 1'b0);
    chk("errOff", 8'h1, {7'h0, access_error_flag});
    chk("secOff", 8'hff, secR);
    @(posedge ref_clk);
    sSec <= 8'h83;
    do_reset(2);
    u_cpu.issue(SK, 1'b0);
    chk("secOpen", 8'h82, secR);
    chk("ccifVfy", 8'h1, {7'h0, command_complete_flag});
    chk("errOk", 8'h0, {7'h0, access_error_flag});
    chk("rewrite", 8'h1, {7'h0, rwOk});
    chk("protVfy", sProt, protR);
    chk("optVfy", sOpt, optR);
    @(posedge ref_clk);
    sSec <= 8'hb3;
    @(posedge ref_clk);
    #1;
    chk("secHold", 8'h82, secR);
    do_reset(2);
    u_cpu.issue(~SK ^ ~SK | ~64'h0, 1'b0);
    chk("errOnes", 8'h1, {7'h0, access_error_flag});
    chk("secOnes", 8'hb3, secR);
    do_reset(2);
    u_cpu.issue(SK ^ 64'h0100000000000000, 1'b0);
    chk("errByte", 8'h1, {7'h0, access_error_flag});
    chk("lockSet", 8'h1, {7'h0, lockOut});
    u_cpu.issue(SK, 1'b0);
    chk("errLock", 8'h1, {7'h0, access_error_flag});
    chk("secLock", 8'hb3, secR);
    chk("rewriteLock", 8'h0, {7'h0, rwOk});
    do_reset(2);
    u_cpu.issue(SK, 1'b1);
    do_reset(2);
    repeat (5) @(posedge ref_clk);
    #1;
    chk("secAbort", 8'hb3, secR);
    chk("errAbort", 8'h0, {7'h0, access_error_flag});
    end_sim();
  end
endmodule : testbench
